// ---- hdl/ipes_slave.sv ----
// I2C slave with paged writes, read counter and busy window
module ipes_slave #(
	parameter int NV_CYCLES = ipes_pkg::NV_WRITE_CYCLES // Busy length
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         sclIn,
	input  wire logic         sdaIn,
	output logic              sdaOut,
	output logic              sdaOeN,
	input  wire logic         immediateUpdatePin,
	input  wire logic         addressSelectPin,
	output logic              wrValid,
	output ipes_pkg::ipes_wr_t wrItem,
	input  wire logic         wrReady,
	output logic [7:0]        rdAddr,
	input  wire logic [7:0]   rdData,
	output logic              nvCommit,
	output logic              busy
);
	localparam int CW = $clog2(NV_CYCLES + 1);

	// ******************************
	// Pin synchronisers
	// ******************************
	logic [1:0] sclSync_q;  // SCL two-stage
	logic [1:0] sdaSync_q;  // SDA two-stage
	logic [1:0] ldSync_q;   // Load pin two-stage
	logic [1:0] selSync_q;  // Select pin two-stage
	logic       sclPrev_q;  // SCL one cycle older
	logic       sdaPrev_q;  // SDA one cycle older

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclSync_q <= 2'b11;
			sdaSync_q <= 2'b11;
			ldSync_q  <= 2'b00;
			selSync_q <= 2'b00;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclSync_q <= {sclSync_q[0], sclIn};
			sdaSync_q <= {sdaSync_q[0], sdaIn};
			ldSync_q  <= {ldSync_q[0], immediateUpdatePin};
			selSync_q <= {selSync_q[0], addressSelectPin};
			sclPrev_q <= sclSync_q[1];
			sdaPrev_q <= sdaSync_q[1];
		end
	end

	// ******************************
	// Bus events
	// ******************************
	wire scl       = sclSync_q[1];
	wire sda       = sdaSync_q[1];
	wire sclRise   = scl && !sclPrev_q;
	wire sclFall   = !scl && sclPrev_q;
	wire startSeen = scl && sclPrev_q && sdaPrev_q && !sda;
	wire stopSeen  = scl && sclPrev_q && !sdaPrev_q && sda;

	// ******************************
	// Transaction state
	// ******************************
	ipes_pkg::ipes_state_t state_q;   // Transaction phase
	logic [3:0]  bitCnt_q;            // Bits moved in this byte
	logic [7:0]  shift_q;             // Received bits
	logic [7:0]  tx_q;                // Bits left to send
	logic [7:0]  addrCnt_q;           // Internal address counter
	logic        ackPhase_q;          // Inside the ninth bit
	logic        sdaLow_q;            // Pulling SDA low
	logic        wrote_q;             // Byte written since last STOP
	logic [CW-1:0] busyCnt_q;         // Nonvolatile write timer
	logic        busy_q;              // Write in progress
	logic        commit_q;            // Start of nonvolatile copy

	// Own seven-bit address from the select pin
	wire [6:0] ownAddr = ipes_pkg::DEV_ADDR_BASE |
		(7'(selSync_q[1]) << ipes_pkg::SEL_BIT_POS);
	wire       byteDone = (bitCnt_q == ipes_pkg::BITS_PER_BYTE);
	wire       addrHit  = (shift_q[7:1] == ownAddr) && !busy_q;

	// Row-bounded step of the counter
	function automatic logic [7:0] nextInRow(input logic [7:0] a);
		logic [ipes_pkg::ROW_BITS-1:0] low;
		low = a[ipes_pkg::ROW_BITS-1:0] + 1'b1;
		nextInRow = {a[7:ipes_pkg::ROW_BITS], low};
	endfunction

	// ******************************
	// Write path buffer
	// ******************************
	ipes_pkg::ipes_wr_t pushItem;    // Byte being accepted
	logic               bufReady;    // Buffer has room
	wire                pushNow = (state_q == ipes_pkg::ST_WDATA) &&
		sclFall && !ackPhase_q && byteDone && bufReady;

	assign pushItem = '{addr: addrCnt_q, data: shift_q,
		live: ldSync_q[1]};

	ipes_buffer #(
		.W     ($bits(ipes_pkg::ipes_wr_t)),
		.DEPTH (2)
	) u_buf (
		.clk      (clk),
		.rstn     (rstn),
		.inValid  (pushNow),
		.inData   (pushItem),
		.inReady  (bufReady),
		.outValid (wrValid),
		.outData  (wrItem),
		.outReady (wrReady)
	);

	// ******************************
	// Byte and bit sequencing
	// ******************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q    <= ipes_pkg::ST_IDLE;
			bitCnt_q   <= 4'h0;
			shift_q    <= 8'h00;
			tx_q       <= 8'h00;
			addrCnt_q  <= ipes_pkg::ADDR_RST;
			ackPhase_q <= 1'b0;
			sdaLow_q   <= 1'b0;
			wrote_q    <= 1'b0;
		end else if (startSeen) begin
			state_q    <= ipes_pkg::ST_DEVADDR;
			bitCnt_q   <= 4'h0;
			ackPhase_q <= 1'b0;
			sdaLow_q   <= 1'b0;
		end else if (stopSeen) begin
			// Back to idle, bus released
			state_q    <= ipes_pkg::ST_IDLE;
			ackPhase_q <= 1'b0;
			sdaLow_q   <= 1'b0;
			wrote_q    <= 1'b0;
		end else if (sclRise && ackPhase_q) begin
			// Master NACK ends the read
			if (state_q == ipes_pkg::ST_RDATA && sda) begin
				state_q <= ipes_pkg::ST_IGNORE;
			end
		end else if (sclRise && !byteDone) begin
			// Sample one bit, MSB first
			shift_q  <= {shift_q[6:0], sda};
			bitCnt_q <= bitCnt_q + 4'h1;
		end else if (sclFall && ackPhase_q) begin
			// End of ninth bit
			ackPhase_q <= 1'b0;
			bitCnt_q   <= 4'h0;
			if (state_q == ipes_pkg::ST_RDATA) begin
				tx_q     <= rdData;
				sdaLow_q <= !rdData[7];
			end else begin
				sdaLow_q <= 1'b0;
			end
		end else if (sclFall && byteDone) begin
			case (state_q)
				ipes_pkg::ST_DEVADDR: begin
					if (addrHit) begin
						ackPhase_q <= 1'b1;
						sdaLow_q   <= 1'b1;
						state_q    <= shift_q[0] ? ipes_pkg::ST_RDATA
							: ipes_pkg::ST_MEMADDR;
					end else begin
						state_q <= ipes_pkg::ST_IGNORE;
					end
				end
				ipes_pkg::ST_MEMADDR: begin
					addrCnt_q  <= shift_q;
					ackPhase_q <= 1'b1;
					sdaLow_q   <= 1'b1;
					state_q    <= ipes_pkg::ST_WDATA;
				end
				ipes_pkg::ST_WDATA: begin
					if (bufReady) begin
						addrCnt_q  <= nextInRow(addrCnt_q);
						ackPhase_q <= 1'b1;
						sdaLow_q   <= 1'b1;
						wrote_q    <= 1'b1;
					end else begin
						// Stall: byte refused with NACK
						state_q <= ipes_pkg::ST_IGNORE;
					end
				end
				ipes_pkg::ST_RDATA: begin
					addrCnt_q  <= addrCnt_q + 8'h01;
					ackPhase_q <= 1'b1;
					sdaLow_q   <= 1'b0;
				end
				default: begin
					bitCnt_q <= 4'h0;
				end
			endcase
		end else if (sclFall && state_q == ipes_pkg::ST_RDATA) begin
			// Next read bit on falling edge
			tx_q     <= {tx_q[6:0], 1'b0};
			sdaLow_q <= !tx_q[6];
		end
	end

	// ******************************
	// Nonvolatile write timer
	// ******************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busyCnt_q <= '0;
			busy_q    <= 1'b0;
			commit_q  <= 1'b0;
		end else begin
			commit_q <= stopSeen && wrote_q;
			if (stopSeen && wrote_q) begin
				busyCnt_q <= CW'(NV_CYCLES);
				busy_q    <= 1'b1;
			end else if (busyCnt_q != '0) begin
				busyCnt_q <= busyCnt_q - 1'b1;
				busy_q    <= (busyCnt_q != CW'(1));
			end
		end
	end

	// ******************************
	// Outputs
	// ******************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sdaOut <= 1'b0;
			sdaOeN <= 1'b1;
		end else begin
			sdaOut <= 1'b0;
			sdaOeN <= !sdaLow_q;
		end
	end

	assign rdAddr   = addrCnt_q;
	assign nvCommit = commit_q;
	assign busy     = busy_q;
endmodule

// ---- hdl/ipes_pkg.sv ----
// Constants and types of the paged I2C slave
package ipes_pkg;

	// ******************************
	// Addressing
	// ******************************
	localparam logic [6:0] DEV_ADDR_BASE = 7'h60; // Address with select low
	localparam int         SEL_BIT_POS   = 0;     // Select pin bit in address
	localparam int         ROW_BITS      = 3;     // Eight bytes per row

	// ******************************
	// Timing
	// ******************************
	localparam int CLK_MHZ          = 20;    // Core clock rate
	localparam int NV_WRITE_TIME_US = 10000; // Nonvolatile write time
	localparam int NV_WRITE_CYCLES  = NV_WRITE_TIME_US * CLK_MHZ;

	// ******************************
	// Reset values
	// ******************************
	localparam logic [7:0] ADDR_RST = 8'h00; // Address counter at reset
	localparam logic [3:0] BITS_PER_BYTE = 4'h8; // Data bits in a byte

	// Transaction states, Gray coded along the usual path
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_DEVADDR = 3'b001,
		ST_MEMADDR = 3'b011,
		ST_WDATA   = 3'b010,
		ST_RDATA   = 3'b110,
		ST_IGNORE  = 3'b100
	} ipes_state_t;

	// One written byte on its way to the memory side
	typedef struct packed {
		logic [7:0] addr; // Target location
		logic [7:0] data; // Byte value
		logic       live; // Update converter now
	} ipes_wr_t;

endpackage

// ---- hdl/ipes_buffer.sv ----
// Two-entry buffer with valid and ready on both sides
module ipes_buffer #(
	parameter int W     = 17, // Word width
	parameter int DEPTH = 2   // Number of entries
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         inValid,
	input  wire logic [W-1:0] inData,
	output logic              inReady,
	output logic              outValid,
	output logic [W-1:0]      outData,
	input  wire logic         outReady
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ******************************
	// Storage and pointers
	// ******************************
	logic [W-1:0]  mem_q [DEPTH];     // Entries
	logic [PW-1:0] wrPtr_q;           // Next free slot
	logic [PW-1:0] rdPtr_q;           // Oldest slot
	logic [PW:0]   count_q;           // Entries held
	wire           push = inValid && inReady;
	wire           pop  = outValid && outReady;

	// Honest full and empty
	assign inReady  = (count_q != (PW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData  = mem_q[rdPtr_q];

	// Pointer wrap
	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// Entry write
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wrPtr_q] <= inData;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) wrPtr_q <= bump(wrPtr_q);
			if (pop) rdPtr_q <= bump(rdPtr_q);
			count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

// ---- tb/ipes_properties.sv ----
// Port checker of the paged I2C slave, bound to its top
module ipes_properties #(
	parameter int NV_CYCLES = 50 // Busy length
) (
	input wire logic               clk,
	input wire logic               rstn,
	input wire logic               sclIn,
	input wire logic               sdaIn,
	input wire logic               sdaOeN,
	input wire logic               wrValid,
	input wire ipes_pkg::ipes_wr_t wrItem,
	input wire logic               wrReady,
	input wire logic [7:0]         rdAddr,
	input wire logic               nvCommit,
	input wire logic               busy
);
	timeunit 1ns;
	timeprecision 1ns;
	int busyLen_q; // Cycles busy has stood high

	// Length of the current busy window
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			busyLen_q <= 0;
		else
			busyLen_q <= busy ? busyLen_q + 1 : 0;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	a_commit_pulse: assert property (nvCommit |=> !nvCommit)
		else $error("commit pulse longer than one cycle");
	a_commit_stop: assert property (nvCommit |-> sclIn && sdaIn)
		else $error("commit without a stop on the bus");
	a_busy_start: assert property (nvCommit |-> ##[0:1] busy)
		else $error("busy did not follow commit");
	a_busy_len: assert property ($fell(busy) |-> busyLen_q == NV_CYCLES)
		else $error("busy window of wrong length");
	a_busy_quiet: assert property (busy |-> sdaOeN)
		else $error("data line driven while busy");
	a_busy_addr: assert property (busy && $past(busy) |-> $stable(rdAddr))
		else $error("counter moved while busy");
	a_item_hold: assert property (wrValid && !wrReady |=>
		wrValid && $stable(wrItem))
		else $error("stalled write item changed");
	a_bit_stable: assert property (sclIn && $past(sclIn, 3) |->
		$stable(sdaOeN))
		else $error("data drive changed while clock high");

	cover property (nvCommit);
	cover property (wrValid && !wrReady);
	cover property (!sdaOeN && sclIn);
endmodule

bind ipes_slave ipes_properties #(.NV_CYCLES(NV_CYCLES)) ipes_properties_i (
	.clk, .rstn, .sclIn, .sdaIn, .sdaOeN, .wrValid, .wrItem, .wrReady,
	.rdAddr, .nvCommit, .busy);

// ---- tb/ipes_master.sv ----
// Bus master model driving the link for the bench
module ipes_master (
	input  wire logic clk,
	input  wire logic sdaOeN,
	output logic      sclIn,
	output logic      sdaIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pullLow = 1'b0; // Master pulls data low
	initial sclIn = 1'b1;
	// Open-drain data wire with pull-up
	assign sdaIn = !(pullLow || !sdaOeN);

	task automatic hp(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One bit: data moves mid-low, sampled late in high
	task automatic bitx(input logic b, output logic s);
		hp(2);
		pullLow <= !b;
		hp(2);
		sclIn <= 1'b1;
		hp(4);
		s = sdaIn;
		sclIn <= 1'b0;
	endtask
	// Start or repeated start, clock left low
	task automatic start();
		pullLow <= 1'b0;
		hp(4);
		sclIn <= 1'b1;
		hp(4);
		pullLow <= 1'b1;
		hp(4);
		sclIn <= 1'b0;
	endtask
	// Stop, both lines left high
	task automatic stop();
		hp(2);
		pullLow <= 1'b1;
		hp(2);
		sclIn <= 1'b1;
		hp(4);
		pullLow <= 1'b0;
		hp(4);
	endtask
	// Nine bits, most significant first
	task automatic xfer(input logic [8:0] v, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
			bitx(v[i], r[i]);
	endtask
endmodule

// ---- tb/test_i2c_paged_eeprom_slave.sv ----
// Self-checking bench of the paged I2C slave
module test_i2c_paged_eeprom_slave;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rstn = 1'b0, ld = 1'b0, sel = 1'b0, stall = 1'b0;
	logic scl, sda, oeN, wrValid, commit, busy, wrReady = 1'b0;
	ipes_pkg::ipes_wr_t wrItem;
	logic [7:0]  rdAddr, mem [256], em [256], ctr;
	logic [16:0] q [$];
	int fail_count = 0, num_checks = 0, cyc = 0, seed = 32'h0000_adf7;

	ipes_slave #(.NV_CYCLES(200)) ipes_slave_i (
		.clk, .rstn, .sclIn(scl), .sdaIn(sda), .sdaOut(), .sdaOeN(oeN),
		.immediateUpdatePin(ld), .addressSelectPin(sel), .wrValid,
		.wrItem, .wrReady, .rdAddr, .rdData(mem[rdAddr]),
		.nvCommit(commit), .busy);
	ipes_master ipes_master_i (.clk, .sdaOeN(oeN), .sclIn(scl), .sdaIn(sda));

	initial forever #25 clk = ~clk;

	task automatic stop_test();
		if (fail_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [16:0] a, input logic [16:0] e);
		num_checks++;
		if (a !== e) begin
			fail_count++;
			$display("FAIL %0t got %h exp %h", $time, a, e);
		end
	endtask
	// Byte to the slave, acknowledge compared
	task automatic wb(input logic [7:0] b, input logic eAck);
		logic [8:0] r;
		ipes_master_i.xfer({b, 1'b1}, r);
		chk(17'(r[0]), 17'(!eAck));
	endtask
	// Data byte: model steps inside its row
	task automatic wd(input logic [7:0] b);
		q.push_back({ctr, b, ld});
		em[ctr] = b;
		ctr = {ctr[7:3], ctr[2:0] + 3'h1};
		wb(b, 1'b1);
	endtask
	// Read byte: model steps without wrap
	task automatic rd(input logic ack);
		logic [8:0] r;
		ipes_master_i.xfer({8'hff, !ack}, r);
		chk(17'(r[8:1]), 17'(em[ctr]));
		ctr++;
	endtask
	task automatic waitIdle();
		for (int i = 0; i < 400 && busy !== 1'b0; i++)
			@(posedge clk);
	endtask

	// Consumer with random stalls, and the run limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		wrReady <= !stall && 1'($random(seed));
		if (cyc == 20000) begin
			fail_count++;
			stop_test();
		end
		if (rstn && wrValid === 1'b1 && wrReady) begin
			mem[wrItem.addr] <= wrItem.data;
			chk(wrItem, q.pop_front());
		end
	end

	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i * 7);
			em[i] = 8'(i * 7);
		end
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		// Page write running over the row end
		ld <= 1'b1;
		ipes_master_i.start();
		wb(8'hc0, 1'b1);
		wb(8'h05, 1'b1);
		ctr = 8'h05;
		repeat (10) wd(8'($random(seed)));
		ipes_master_i.stop();
		ipes_master_i.start();
		wb(8'hc0, 1'b0);
		ipes_master_i.stop();
		waitIdle();
		// Dummy write, then read across the row
		ld <= 1'b0;
		ipes_master_i.start();
		wb(8'hc0, 1'b1);
		wb(8'h06, 1'b1);
		ctr = 8'h06;
		ipes_master_i.start();
		wb(8'hc1, 1'b1);
		rd(1'b1);
		rd(1'b1);
		rd(1'b0);
		ipes_master_i.stop();
		ipes_master_i.start();
		wb(8'hc1, 1'b1);
		rd(1'b0);
		ipes_master_i.stop();
		// Foreign address, then its byte ignored
		ipes_master_i.start();
		wb(8'hc2, 1'b0);
		wb(8'hc0, 1'b0);
		ipes_master_i.stop();
		// Select pin high, buffer filled until refusal
		sel <= 1'b1;
		ld <= 1'($random(seed));
		stall <= 1'b1;
		ipes_master_i.start();
		wb(8'hc2, 1'b1);
		wb(8'h18, 1'b1);
		ctr = 8'h18;
		wd(8'($random(seed)));
		wd(8'($random(seed)));
		wb(8'h3c, 1'b0);
		ipes_master_i.stop();
		stall <= 1'b0;
		waitIdle();
		ipes_master_i.start();
		wb(8'hc2, 1'b1);
		wb(8'h18, 1'b1);
		ctr = 8'h18;
		ipes_master_i.start();
		wb(8'hc3, 1'b1);
		rd(1'b1);
		rd(1'b0);
		ipes_master_i.stop();
		repeat (20) @(posedge clk);
		stop_test();
	end
endmodule
